/* File: design/rmpu_top.sv */
// region memory protection unit: register file and access checker
`timescale 1ns/1ps
`default_nettype none
module rmpu_top
  import rmpu_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // register port of the peripheral path
  input wire logic i_reg_en,
  input wire logic i_reg_we,
  input wire logic [31:0] i_reg_addr,
  input wire logic [1:0] i_reg_size,
  input wire logic [31:0] i_reg_wdata,
  output logic o_reg_ack,
  output logic o_reg_err,
  output logic [31:0] o_reg_rdata,
  // access check port of the core
  input wire logic i_acc_valid,
  input wire logic [31:0] i_acc_addr,
  input wire logic i_acc_write,
  input wire logic i_acc_priv,
  input wire logic i_acc_fetch,
  input wire logic i_exc_boundary,
  output logic o_acc_done,
  output logic o_acc_grant,
  output logic o_acc_fault,
  output logic o_acc_background,
  output logic [3:0] o_acc_region,
  output logic [2:0] o_acc_tex,
  output logic o_acc_s,
  output logic o_acc_c,
  output logic o_acc_b,
  output logic o_acc_strong,
  output logic o_barrier,
  output logic [7:0] o_memmanage_fault_status
);

  // ==========================================================
  // configuration state
  logic unit_enable;
  logic [2:0] region_select;
  logic [26:0] region_base [RMPU_REGIONS];
  logic [31:0] region_attribute_size [RMPU_REGIONS];
  logic [7:0] memmanage_fault_status;
  logic [31:0] fault_address;

  // ==========================================================
  // register port decode
  rmpu_reg_e reg_kind;
  logic misaligned;
  logic bad_size;
  logic reg_bad;
  logic reg_wr;
  logic reg_rd;
  logic base_valid;
  logic [2:0] wr_region;
  logic [3:0] lane_en;

  assign reg_kind = rmpu_decode(i_reg_addr);

  always_comb begin
    misaligned = 1'b0;
    bad_size = 1'b0;
    lane_en = 4'h0;
    unique case (i_reg_size)
      RMPU_SZ_BYTE: begin
        lane_en = 4'h1 << i_reg_addr[1:0];
      end
      RMPU_SZ_HALF: begin
        misaligned = i_reg_addr[0];
        lane_en = i_reg_addr[1] ? 4'hC : 4'h3;
      end
      RMPU_SZ_WORD: begin
        misaligned = i_reg_addr[1:0] != 2'h0;
        lane_en = 4'hF;
      end
      default: begin
        bad_size = 1'b1;
      end
    endcase
  end

  // only the attribute/size words take sub-word accesses
  assign reg_bad = (reg_kind == RMPU_REG_NONE) || misaligned || bad_size ||
                   (i_reg_size != RMPU_SZ_WORD &&
                    reg_kind != RMPU_REG_ATTR);
  assign reg_wr = i_reg_en && i_reg_we && !reg_bad;
  assign reg_rd = i_reg_en && !i_reg_we && !reg_bad;

  assign base_valid = (reg_kind == RMPU_REG_BASE) &&
                      i_reg_wdata[RMPU_BASE_VALID_BIT];
  // a valid base word names its own region
  assign wr_region = base_valid ? i_reg_wdata[2:0] : region_select;

  // ==========================================================
  // unit enable
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      unit_enable <= 1'b0;
    end else if (reg_wr && reg_kind == RMPU_REG_CTRL) begin
      unit_enable <= i_reg_wdata[RMPU_CTRL_EN_BIT];
    end
  end

  // ==========================================================
  // region select
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      region_select <= RMPU_RESET_SELECT;
    end else if (reg_wr && reg_kind == RMPU_REG_SELECT) begin
      region_select <= i_reg_wdata[2:0];
    end else if (reg_wr && base_valid) begin
      region_select <= i_reg_wdata[2:0];
    end
  end

  // ==========================================================
  // region base and attribute/size tables, one per region
  // writes land in the cycle they arrive, one per cycle, in order
  generate
    for (genvar r = 0; r < RMPU_REGIONS; r++) begin : g_region
      logic sel_here;
      assign sel_here = wr_region == RMPU_RIDX_W'(r);

      always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          region_base[r] <= RMPU_RESET_WORD[31:RMPU_BASE_LSB];
        end else if (reg_wr && reg_kind == RMPU_REG_BASE && sel_here) begin
          region_base[r] <= i_reg_wdata[31:RMPU_BASE_LSB];
        end
      end

      // alias words reach the same tables as the first pair
      for (genvar l = 0; l < 4; l++) begin : g_lane
        always_ff @(posedge i_core_clk or negedge i_resetn) begin
          if (!i_resetn) begin
            region_attribute_size[r][8*l +: 8] <= RMPU_RESET_WORD[8*l +: 8];
          end else if (reg_wr && reg_kind == RMPU_REG_ATTR && sel_here &&
                       lane_en[l]) begin
            region_attribute_size[r][8*l +: 8] <=
              i_reg_wdata[8*l +: 8] & RMPU_ATTR_WMASK[8*l +: 8];
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // register read data and answer
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (reg_kind)
      RMPU_REG_CTRL: rd_word = {31'h0000_0000, unit_enable};
      RMPU_REG_SELECT: rd_word = {29'h0000_0000, region_select};
      RMPU_REG_BASE: begin
        rd_word = {region_base[region_select], 2'h0, region_select};
      end
      RMPU_REG_ATTR: rd_word = region_attribute_size[region_select];
      RMPU_REG_FSTAT: rd_word = {24'h00_0000, memmanage_fault_status};
      RMPU_REG_FADDR: rd_word = fault_address;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_ack <= 1'b0;
      o_reg_err <= 1'b0;
    end else begin
      o_reg_ack <= i_reg_en;
      o_reg_err <= i_reg_en && reg_bad;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= RMPU_RESET_WORD;
    end else if (reg_rd) begin
      o_reg_rdata <= rd_word;
    end else if (i_reg_en) begin
      o_reg_rdata <= RMPU_RESET_WORD;
    end
  end

  // ==========================================================
  // region matching against the shared table
  logic [RMPU_REGIONS-1:0] hit;

  generate
    for (genvar r = 0; r < RMPU_REGIONS; r++) begin : g_match
      rmpu_region_match u_match (
        .i_addr(i_acc_addr),
        .i_base(region_base[r]),
        .i_attr(region_attribute_size[r]),
        .o_hit(hit[r])
      );
    end
  endgenerate

  // ==========================================================
  // pick winning region
  logic any_hit;
  logic [2:0] win;
  logic [31:0] win_attr;

  always_comb begin
    any_hit = 1'b0;
    win = 3'h0;
    for (int r = 0; r < RMPU_REGIONS; r++) begin
      if (hit[r]) begin
        any_hit = 1'b1;
        win = RMPU_RIDX_W'(r);
      end
    end
  end

  assign win_attr = region_attribute_size[win];

  // ==========================================================
  // permission of the winning region
  logic region_allow;
  logic allow;
  logic use_background;

  rmpu_perm_check u_perm (
    .i_perm(win_attr[RMPU_AP_LSB +: 3]),
    .i_xn(win_attr[RMPU_XN_BIT]),
    .i_priv(i_acc_priv),
    .i_write(i_acc_write),
    .i_fetch(i_acc_fetch),
    .o_allow(region_allow)
  );

  assign use_background = unit_enable && !any_hit;

  always_comb begin
    if (!unit_enable) begin
      allow = 1'b1;
    end else if (any_hit) begin
      allow = region_allow;
    end else begin
      allow = i_acc_priv;
    end
  end

  // ==========================================================
  // access answer, one per request, in request order
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_acc_done <= 1'b0;
      o_acc_grant <= 1'b0;
      o_acc_fault <= 1'b0;
    end else begin
      o_acc_done <= i_acc_valid;
      o_acc_grant <= i_acc_valid && allow;
      o_acc_fault <= i_acc_valid && !allow;
    end
  end

  // attributes; background gives default map marking, disabled unit gives zero attributes without it
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_acc_background <= 1'b0;
      o_acc_region <= 4'h0;
      o_acc_tex <= 3'h0;
      o_acc_s <= 1'b0;
      o_acc_c <= 1'b0;
      o_acc_b <= 1'b0;
      o_acc_strong <= 1'b0;
    end else if (i_acc_valid) begin
      o_acc_background <= use_background;
      o_acc_region <= (unit_enable && any_hit) ? {1'b1, win} : 4'h0;
      if (unit_enable && any_hit) begin
        o_acc_tex <= win_attr[RMPU_TEX_LSB +: 3];
        o_acc_s <= win_attr[RMPU_S_BIT];
        o_acc_c <= win_attr[RMPU_C_BIT];
        o_acc_b <= win_attr[RMPU_B_BIT];
        o_acc_strong <= win_attr[RMPU_TEX_LSB +: 3] == 3'h0 &&
                        !win_attr[RMPU_C_BIT] &&
                        !win_attr[RMPU_B_BIT];
      end else begin
        o_acc_tex <= 3'h0;
        o_acc_s <= 1'b0;
        o_acc_c <= 1'b0;
        o_acc_b <= 1'b0;
        o_acc_strong <= 1'b0;
      end
    end
  end

  // ==========================================================
  // barrier at exception entry or return
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_barrier <= 1'b0;
    end else begin
      o_barrier <= i_exc_boundary;
    end
  end

  // ==========================================================
  // fault status, write one to clear, new fault wins over clear
  logic fault_now;
  logic [7:0] fs_set;
  logic [7:0] fs_clr;

  assign fault_now = i_acc_valid && !allow;
  assign fs_set = {fault_now && !i_acc_fetch, 5'h00,
                   fault_now && !i_acc_fetch, fault_now && i_acc_fetch};
  assign fs_clr = (reg_wr && reg_kind == RMPU_REG_FSTAT && lane_en[0]) ?
                  i_reg_wdata[7:0] : 8'h00;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      memmanage_fault_status <= RMPU_RESET_WORD[7:0];
    end else begin
      memmanage_fault_status <=
        (memmanage_fault_status & ~fs_clr) | fs_set;
    end
  end

  // fault address held while its valid flag stands
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fault_address <= RMPU_RESET_WORD;
    end else if (fs_set[RMPU_FS_DACC_BIT] &&
                 (!memmanage_fault_status[RMPU_FS_AVALID_BIT] ||
                  fs_clr[RMPU_FS_AVALID_BIT])) begin
      fault_address <= i_acc_addr;
    end
  end

  assign o_memmanage_fault_status = memmanage_fault_status;

endmodule
`default_nettype wire

/* File: common/rmpu_pkg.sv */
// constants, register map and field layout of the region protection unit
package rmpu_pkg;

  // ==========================================================
  // geometry
  localparam int RMPU_REGIONS = 8;
  localparam int RMPU_RIDX_W = 3;

  // ==========================================================
  // register byte addresses
  localparam logic [31:0] RMPU_ADDR_CTRL = 32'hE000_ED94;
  localparam logic [31:0] RMPU_ADDR_SELECT = 32'hE000_ED98;
  localparam logic [31:0] RMPU_ADDR_BASE = 32'hE000_ED9C;
  localparam logic [31:0] RMPU_ADDR_ATTR = 32'hE000_EDA0;
  localparam logic [31:0] RMPU_ADDR_ALIAS_LAST = 32'hE000_EDB8;
  localparam logic [31:0] RMPU_ADDR_FSTAT = 32'hE000_ED28;
  localparam logic [31:0] RMPU_ADDR_FADDR = 32'hE000_ED34;

  // ==========================================================
  // field positions
  localparam int RMPU_CTRL_EN_BIT = 0;
  localparam int RMPU_BASE_VALID_BIT = 4;
  localparam int RMPU_BASE_LSB = 5;
  localparam int RMPU_ATTR_EN_BIT = 0;
  localparam int RMPU_SIZE_LSB = 1;
  localparam int RMPU_SRD_LSB = 8;
  localparam int RMPU_B_BIT = 16;
  localparam int RMPU_C_BIT = 17;
  localparam int RMPU_S_BIT = 18;
  localparam int RMPU_TEX_LSB = 19;
  localparam int RMPU_AP_LSB = 24;
  localparam int RMPU_XN_BIT = 28;
  localparam logic [31:0] RMPU_ATTR_WMASK = 32'h173F_FF3F;
  localparam int RMPU_FS_IACC_BIT = 0;
  localparam int RMPU_FS_DACC_BIT = 1;
  localparam int RMPU_FS_AVALID_BIT = 7;

  // ==========================================================
  // size encodings: region bytes = 2^(size+1)
  localparam logic [4:0] RMPU_SIZE_MIN = 5'h04;
  localparam logic [4:0] RMPU_SIZE_SUBREG_MIN = 5'h07;

  // ==========================================================
  // values after reset
  localparam logic [31:0] RMPU_RESET_WORD = 32'h0000_0000;
  localparam logic [2:0] RMPU_RESET_SELECT = 3'h0;

  // ==========================================================
  // register decode
  typedef enum logic [2:0] {
    RMPU_REG_NONE, RMPU_REG_CTRL, RMPU_REG_SELECT, RMPU_REG_BASE,
    RMPU_REG_ATTR, RMPU_REG_FSTAT, RMPU_REG_FADDR
  } rmpu_reg_e;

  typedef enum logic [1:0] {
    RMPU_SZ_BYTE = 2'h0, RMPU_SZ_HALF = 2'h1, RMPU_SZ_WORD = 2'h2
  } rmpu_size_e;

  // base and attribute pairs repeat every 8 bytes up to the last alias
  function automatic rmpu_reg_e rmpu_decode(input logic [31:0] a);
    logic [31:0] w;
    w = {a[31:2], 2'b00};
    if (w == RMPU_ADDR_CTRL) return RMPU_REG_CTRL;
    if (w == RMPU_ADDR_SELECT) return RMPU_REG_SELECT;
    if (w == RMPU_ADDR_FSTAT) return RMPU_REG_FSTAT;
    if (w == RMPU_ADDR_FADDR) return RMPU_REG_FADDR;
    if (w >= RMPU_ADDR_BASE && w <= RMPU_ADDR_ALIAS_LAST)
      return (w[2] == RMPU_ADDR_BASE[2]) ? RMPU_REG_BASE : RMPU_REG_ATTR;
    return RMPU_REG_NONE;
  endfunction

endpackage

/* File: design/rmpu_region_match.sv */
// address match of one protection region with subregion masking
`timescale 1ns/1ps
`default_nettype none
module rmpu_region_match
  import rmpu_pkg::*;
(
  input wire logic [31:0] i_addr,
  input wire logic [26:0] i_base,
  input wire logic [31:0] i_attr,
  output logic o_hit
);

  logic [4:0] size;
  logic [31:0] mask;
  logic [31:0] offset;
  logic [31:0] sub_word;
  logic [2:0] sub_idx;
  logic in_range;
  logic sub_off;

  assign size = i_attr[RMPU_SIZE_LSB +: 5];
  // six-bit shift so that the largest size clears the whole mask
  assign mask = 32'hFFFF_FFFF << ({1'b0, size} + 6'h01);
  assign in_range = ((i_addr ^ {i_base, 5'h00}) & mask) == 32'h0000_0000;
  assign offset = i_addr & ~mask;
  // eight equal subregions of a region of 256 bytes or more
  assign sub_word = offset >> (size - 5'h02);
  assign sub_idx = sub_word[2:0];
  assign sub_off = (size >= RMPU_SIZE_SUBREG_MIN) &&
                   i_attr[RMPU_SRD_LSB + int'(sub_idx)];

  assign o_hit = i_attr[RMPU_ATTR_EN_BIT] && (size >= RMPU_SIZE_MIN) &&
                 in_range && !sub_off;

endmodule
`default_nettype wire

/* File: design/rmpu_perm_check.sv */
// access permission and execute-never check for one access
`timescale 1ns/1ps
`default_nettype none
module rmpu_perm_check (
  input wire logic [2:0] i_perm,
  input wire logic i_xn,
  input wire logic i_priv,
  input wire logic i_write,
  input wire logic i_fetch,
  output logic o_allow
);

  logic priv_rd;
  logic priv_wr;
  logic user_rd;
  logic user_wr;
  logic rd_ok;
  logic wr_ok;

  // ==========================================================
  // permission decode, 100 reserved and denied
  always_comb begin
    priv_rd = 1'b0;
    priv_wr = 1'b0;
    user_rd = 1'b0;
    user_wr = 1'b0;
    unique case (i_perm)
      3'h1: begin
        priv_rd = 1'b1;
        priv_wr = 1'b1;
      end
      3'h2: begin
        priv_rd = 1'b1;
        priv_wr = 1'b1;
        user_rd = 1'b1;
      end
      3'h3: begin
        priv_rd = 1'b1;
        priv_wr = 1'b1;
        user_rd = 1'b1;
        user_wr = 1'b1;
      end
      3'h5: begin
        priv_rd = 1'b1;
      end
      3'h6, 3'h7: begin
        priv_rd = 1'b1;
        user_rd = 1'b1;
      end
      default: begin
        priv_rd = 1'b0;
      end
    endcase
  end

  assign rd_ok = i_priv ? priv_rd : user_rd;
  assign wr_ok = i_priv ? priv_wr : user_wr;
  assign o_allow = i_write ? wr_ok : (rd_ok && !(i_fetch && i_xn));

endmodule
`default_nettype wire

/* File: bench/rmpu_core_model.sv */
// behavioural core access path that issues checked accesses
`timescale 1ns/1ps
`default_nettype none
module rmpu_core_model (
  input wire logic i_clk,
  output logic o_acc_valid,
  output logic [31:0] o_acc_addr,
  output logic o_acc_write,
  output logic o_acc_priv,
  output logic o_acc_fetch
);
  initial begin
    o_acc_valid = 1'h0;
    o_acc_addr = 32'h0000_0000;
    o_acc_write = 1'h0;
    o_acc_priv = 1'h0;
    o_acc_fetch = 1'h0;
  end

  // ==========================================================
  // one access for one cycle, qualifiers scrambled once idle
  task automatic issue(input logic [31:0] a, input bit w, p, f);
    @(negedge i_clk);
    o_acc_valid <= 1'h1;
    o_acc_addr <= a;
    o_acc_write <= w;
    o_acc_priv <= p;
    o_acc_fetch <= f;
    @(negedge i_clk);
    o_acc_valid <= 1'h0;
    o_acc_addr <= ~a;
    o_acc_write <= ~w;
    o_acc_priv <= ~p;
    o_acc_fetch <= ~f;
  endtask
endmodule
`default_nettype wire

/* File: bench/rmpu_checker.sv */
// port checker of the region protection unit
`timescale 1ns/1ps
`default_nettype none
module rmpu_checker (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_reg_en,
  input wire logic [31:0] i_reg_addr,
  input wire logic [1:0] i_reg_size,
  input wire logic o_reg_ack,
  input wire logic o_reg_err,
  input wire logic i_acc_valid,
  input wire logic i_acc_priv,
  input wire logic i_acc_fetch,
  input wire logic i_exc_boundary,
  input wire logic o_acc_done,
  input wire logic o_acc_grant,
  input wire logic o_acc_fault,
  input wire logic o_acc_background,
  input wire logic [3:0] o_acc_region,
  input wire logic [2:0] o_acc_tex,
  input wire logic o_acc_c,
  input wire logic o_acc_b,
  input wire logic o_acc_strong,
  input wire logic o_barrier,
  input wire logic [7:0] o_memmanage_fault_status
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  // ==========================================================
  // register port
  ack_timing_a:
    assert property (i_reg_en |=> o_reg_ack) else $error("no ack");
  bad_size_a:
    assert property (i_reg_en && i_reg_size == 2'h3 |=> o_reg_err)
    else $error("size 3 accepted");
  unaligned_word_a:
    assert property (i_reg_en && i_reg_size == 2'h2 &&
      i_reg_addr[1:0] != 2'h0 |=> o_reg_err) else $error("unaligned ok");
  subword_other_a:
    assert property (i_reg_en && i_reg_size != 2'h2 &&
      !(i_reg_addr >= 32'hE000_EDA0 && i_reg_addr <= 32'hE000_EDBB &&
      !i_reg_addr[2]) |=> o_reg_err) else $error("subword accepted");

  // ==========================================================
  // access port
  access_answer_a:
    assert property (i_acc_valid |=> o_acc_done &&
      (o_acc_grant != o_acc_fault)) else $error("bad access answer");
  bg_priv_a:
    assert property (o_acc_done && o_acc_background |->
      o_acc_grant == $past(i_acc_priv)) else $error("background perm");
  fault_record_a:
    assert property (o_acc_fault |-> ($past(i_acc_fetch) ?
      o_memmanage_fault_status[0] : &o_memmanage_fault_status[7:1] ||
      (o_memmanage_fault_status[1] && o_memmanage_fault_status[7])))
    else $error("fault not recorded");
  barrier_pulse_a:
    assert property (i_exc_boundary |=> o_barrier) else $error("no barrier");
  strong_attr_a:
    assert property (o_acc_region[3] |-> o_acc_strong ==
      (o_acc_tex == 3'h0 && !o_acc_c && !o_acc_b)) else $error("strong");
  bg_region_a:
    assert property (o_acc_background |-> o_acc_region == 4'h0)
    else $error("region on background");

  cover property (o_acc_fault);
  cover property (o_acc_done && o_acc_background && o_acc_grant);
  cover property (o_acc_done && o_acc_region == 4'hF);
endmodule

bind rmpu_top rmpu_checker i_rmpu_checker (
  .i_core_clk, .i_resetn, .i_reg_en, .i_reg_addr, .i_reg_size, .o_reg_ack,
  .o_reg_err, .i_acc_valid, .i_acc_priv, .i_acc_fetch, .i_exc_boundary,
  .o_acc_done, .o_acc_grant, .o_acc_fault, .o_acc_background, .o_acc_region,
  .o_acc_tex, .o_acc_c, .o_acc_b, .o_acc_strong, .o_barrier,
  .o_memmanage_fault_status
);
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench of the region protection unit
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import rmpu_pkg::*;
;
  logic i_core_clk, i_resetn, i_reg_en, i_reg_we, i_exc_boundary;
  logic [31:0] i_reg_addr, i_reg_wdata, o_reg_rdata, i_acc_addr;
  logic [1:0] i_reg_size;
  logic o_reg_ack, o_reg_err, o_acc_done, o_acc_grant, o_acc_fault;
  logic i_acc_valid, i_acc_write, i_acc_priv, i_acc_fetch, o_barrier;
  logic o_acc_background, o_acc_s, o_acc_c, o_acc_b, o_acc_strong;
  logic [3:0] o_acc_region;
  logic [2:0] o_acc_tex;
  logic [7:0] o_memmanage_fault_status;
  logic [31:0] ra[8], rb[8], a;
  logic [2:0] sel;
  logic [7:0] fst;
  bit on, w, f;
  int n_fail, compares, cyc, i, ap;

  rmpu_top i_rmpu_top (.i_core_clk, .i_resetn, .i_reg_en, .i_reg_we,
    .i_reg_addr, .i_reg_size, .i_reg_wdata, .o_reg_ack, .o_reg_err,
    .o_reg_rdata, .i_acc_valid, .i_acc_addr, .i_acc_write, .i_acc_priv,
    .i_acc_fetch, .i_exc_boundary, .o_acc_done, .o_acc_grant, .o_acc_fault,
    .o_acc_background, .o_acc_region, .o_acc_tex, .o_acc_s, .o_acc_c,
    .o_acc_b, .o_acc_strong, .o_barrier, .o_memmanage_fault_status);
  rmpu_core_model i_rmpu_core_model (.i_clk(i_core_clk),
    .o_acc_valid(i_acc_valid), .o_acc_addr(i_acc_addr),
    .o_acc_write(i_acc_write), .o_acc_priv(i_acc_priv),
    .o_acc_fetch(i_acc_fetch));

  always #12.5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      end_of_test();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic end_of_test;
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, y);
    compares++;
    if (y !== x) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, x, y);
    end
  endtask

  task automatic rop(input bit we, input logic [31:0] ad, input logic [1:0] z,
      input logic [31:0] d, input bit xe, input logic [31:0] xr);
    @(negedge i_core_clk);
    i_reg_en <= 1'h1;
    i_reg_we <= we;
    i_reg_addr <= ad;
    i_reg_size <= z;
    i_reg_wdata <= d;
    @(negedge i_core_clk);
    i_reg_en <= 1'h0;
    chk("ack", 1, o_reg_ack);
    chk("err", xe, o_reg_err);
    chk("rdata", xr, o_reg_rdata);
  endtask

  task automatic rd(input logic [31:0] ad, input logic [31:0] xr);
    rop(0, ad, 2'h2, 0, 0, xr);
  endtask

  // reference register file update, then the bus write itself
  task automatic wr(input logic [31:0] ad, input logic [1:0] z,
      input logic [31:0] d);
    int k;
    if (ad == RMPU_ADDR_CTRL) on = d[0];
    else if (ad == RMPU_ADDR_SELECT) sel = d[2:0];
    else if (ad == RMPU_ADDR_FSTAT) fst = fst & ~d[7:0];
    else if (ad[2]) begin
      if (d[4]) sel = d[2:0];
      rb[sel] = d & 32'hFFFF_FFE0;
    end else for (k = 0; k < 4; k++)
      if (z == 2 || (z == 1 && k[1] == ad[1]) || (z == 0 && k == ad[1:0]))
        ra[sel][8*k +: 8] = d[8*k +: 8] & RMPU_ATTR_WMASK[8*k +: 8];
    rop(1, ad, z, d, 0, 0);
  endtask

  function automatic void exp_acc(input logic [31:0] ad, input bit wr_, p,
      fe, output logic [3:0] rg, output bit g);
    int r, s;
    longint unsigned sz;
    rg = 4'h0;
    g = 1;
    if (!on) return;
    for (r = 0; r < 8; r++) begin
      s = (ra[r] >> 1) & 31;
      sz = 64'h0000_0000_0000_0001 << (s + 1);
      if (ra[r][0] && s >= 4 && ((ad ^ rb[r]) & ~(sz - 1)) == 0 &&
          !(s >= 7 && ra[r][8 + ((ad >> (s - 2)) & 7)]))
        rg = {1'h1, r[2:0]};
    end
    if (!rg[3]) g = p;
    else case (ra[rg[2:0]][26:24])
      1: g = p;
      2: g = p | !wr_;
      3: g = 1;
      5: g = p & !wr_;
      6, 7: g = !wr_;
      default: g = 0;
    endcase
    if (rg[3] && fe && ra[rg[2:0]][28]) g = 0;
  endfunction

  task automatic acc(input logic [31:0] ad, input bit wr_, p, fe);
    logic [3:0] xr;
    logic [31:0] at;
    bit g;
    exp_acc(ad, wr_, p, fe, xr, g);
    at = xr[3] ? ra[xr[2:0]] : 32'h0000_0000;
    i_rmpu_core_model.issue(ad, wr_, p, fe);
    chk("done", 1, o_acc_done);
    chk("grant", g, o_acc_grant);
    chk("fault", !g, o_acc_fault);
    chk("region", xr, o_acc_region);
    chk("background", on && !xr[3], o_acc_background);
    chk("attrs", at[21:16], {o_acc_tex, o_acc_s, o_acc_c, o_acc_b});
    chk("strong", xr[3] && at[21:19] == 0 && at[17:16] == 0,
        o_acc_strong);
    if (!g) fst = fst | (fe ? 8'h01 : 8'h82);
    chk("fstat", fst, o_memmanage_fault_status);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {i_core_clk, i_resetn, i_reg_en, i_reg_we, i_exc_boundary} = 5'h00;
    {i_reg_addr, i_reg_wdata, i_reg_size} = 66'h0;
    {n_fail, compares, cyc, on, sel, fst} = 0;
    foreach (ra[k]) {ra[k], rb[k]} = 64'h0;
    void'($urandom(35));
    repeat (12) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_resetn = 1'h1;
    rd(RMPU_ADDR_CTRL, 0);
    rd(RMPU_ADDR_BASE, 0);
    rd(RMPU_ADDR_ATTR, 0);
    acc(32'h2000_0000, 1, 0, 0);
    rop(0, 32'hE000_EDBC, 2'h2, 0, 1, 0);
    rop(1, RMPU_ADDR_SELECT, 2'h0, 5, 1, 0);
    rop(1, RMPU_ADDR_SELECT, 2'h3, 5, 1, 0);
    rop(1, RMPU_ADDR_ATTR + 1, 2'h1, 0, 1, 0);
    rop(1, RMPU_ADDR_SELECT + 2, 2'h2, 5, 1, 0);
    rd(RMPU_ADDR_SELECT, 0);
    wr(RMPU_ADDR_CTRL, 2'h2, 1);
    wr(RMPU_ADDR_SELECT, 2'h2, 0);
    wr(RMPU_ADDR_BASE, 2'h2, 32'h2000_0000);
    wr(RMPU_ADDR_ATTR, 2'h1, 32'h0000_001F);
    wr(RMPU_ADDR_ATTR + 2, 2'h1, 32'h0302_0000);
    rd(RMPU_ADDR_ATTR, ra[0]);
    wr(RMPU_ADDR_BASE + 8, 2'h2, 32'h2000_0011);
    wr(RMPU_ADDR_ATTR + 8, 2'h2, 32'h0100_0317);
    wr(RMPU_ADDR_BASE + 16, 2'h2, 32'h2000_8012);
    wr(RMPU_ADDR_ATTR + 16, 2'h2, 32'h1600_000F);
    wr(RMPU_ADDR_BASE + 24, 2'h2, 32'h2000_F017);
    wr(RMPU_ADDR_ATTR + 24, 2'h2, 32'h0000_0009);
    rd(RMPU_ADDR_SELECT, 7);
    rd(RMPU_ADDR_BASE, {rb[7][31:5], 2'h0, sel});
    acc(32'h2000_F004, 0, 1, 0);
    acc(32'h2000_0010, 1, 0, 0);
    acc(32'h2000_8000, 0, 1, 1);
    for (ap = 0; ap < 8; ap++) begin
      wr(RMPU_ADDR_SELECT, 2'h2, 3);
      wr(RMPU_ADDR_ATTR, 2'h0, 0);
      wr(RMPU_ADDR_BASE, 2'h2, 32'h2001_0000);
      // no exception boundary while attributes change
      wr(RMPU_ADDR_ATTR, 2'h2, {5'h00, ap[2:0], 24'h00_0013});
      for (i = 0; i < 5; i++) acc(32'h2001_0100, i[0], i[1], i[2]);
    end
    for (i = 0; i < 150; i++) begin
      a = 32'h2000_0000 + ($urandom % 32'h0001_2000);
      f = ($urandom % 4) == 0;
      w = !f && $urandom % 2;
      acc(a, w, $urandom % 2, f);
    end
    wr(RMPU_ADDR_SELECT, 2'h2, 1);
    wr(RMPU_ADDR_ATTR, 2'h0, 32'h0000_0016);
    acc(32'h2000_0410, 0, 0, 0);
    rd(RMPU_ADDR_FSTAT, {24'h00_0000, fst});
    wr(RMPU_ADDR_FSTAT, 2'h2, 32'h0000_00FF);
    rd(RMPU_ADDR_FSTAT, 0);
    @(negedge i_core_clk);
    i_exc_boundary <= 1'h1;
    @(negedge i_core_clk);
    i_exc_boundary <= 1'h0;
    chk("barrier", 1, o_barrier);
    end_of_test();
  end
endmodule
`default_nettype wire
